/* File: rtl/reset_brownout_pkg.sv */
package reset_brownout_pkg;
    // register map
    localparam logic [3:0] BROWNOUT_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] SEQ_STATUS_ADDR       = 4'h4;
    localparam int         SW_ENABLE_BIT         = 7;
    localparam int         FAST_START_BIT        = 6;
    localparam int         READY_BIT             = 0;
    localparam logic       SW_ENABLE_RESET       = 1'b1;
    localparam logic       FAST_START_RESET      = 1'b0;
    // brown-out mode encodings
    localparam logic [1:0] MODE_ALWAYS_ON    = 2'h3;
    localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
    localparam logic [1:0] MODE_SOFTWARE     = 2'h1;
    localparam logic [1:0] MODE_ALWAYS_OFF   = 2'h0;
    // timing
    localparam int CLK_HZ            = 25000000;
    localparam int PUT_TIME_MS       = 64;
    localparam int PUT_CYCLES        = PUT_TIME_MS * (CLK_HZ / 1000);
    localparam int DIP_FILTER_NS     = 1000;
    localparam int DIP_FILTER_CYCLES = (DIP_FILTER_NS + 39) / 40;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;
endpackage

/* File: rtl/reset_brownout_sequencer.sv */
// Operation
// - any reset source asserts internal reset
// - hold reset while supply below minimum
// - power-up timer gives 64 ms timeout
// - reset held while power-up timer counts
// - active-low config bit enables power-up timer
// - timer starts after power-on and brown-out release
// - two-bit field selects four brown-out modes
// - only dips longer than filter cause reset
// - mode 11: always on, start waits ready
// - always-on: active in sleep, no wake wait
// - mode 10: off in sleep, start waits
// - off-in-sleep: wake waits for detector ready
// - mode 01: software enable, no start wait
// - software mode: protect once ready, show ready
// - software mode: sleep keeps software enable
// - bit 7 enables detector in software mode
// - bit 6 forces band gap in modes 10/01
// - bit 0 reads detector active state
// - forced-on modes: ready before execution starts
// - control bits reset only on power/brown-out (code also resets them on program-mode exit)
// - low-power brown-out ORed into brown-out reset
// - execution waits timer and external pin release
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module reset_brownout_sequencer #(
    parameter int PUT_COUNT = reset_brownout_pkg::PUT_CYCLES,
    parameter int DIP_COUNT = reset_brownout_pkg::DIP_FILTER_CYCLES
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_power_on_low,
    input  wire logic        i_supply_below_threshold,
    input  wire logic        i_detector_ready,
    input  wire logic        i_low_power_supply_drop_reset,
    input  wire logic        i_external_reset_pin_n,
    input  wire logic        i_external_reset_pin_enable,
    input  wire logic        i_watchdog_timer_reset,
    input  wire logic        i_reset_instruction,
    input  wire logic        i_stack_overflow,
    input  wire logic        i_stack_underflow,
    input  wire logic        i_stack_fault_reset_enable,
    input  wire logic        i_program_mode_exit,
    input  wire logic        i_power_up_timer_enable_n,
    input  wire logic [1:0]  i_supply_drop_mode,
    input  wire logic        i_sleep,
    input  wire logic        i_wake_request,
    output logic             o_internal_reset,
    output logic             o_run_enable,
    output logic             o_detector_enable,
    output logic             o_bandgap_force_on,
    output logic             o_supply_drop_reset,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import reset_brownout_pkg::*;

    typedef enum logic [2:0] {ST_POWER, ST_TIMER, ST_WAIT_READY, ST_HOLD, ST_RUN, ST_WAKE} seq_e;

    // two-flop synchronisers for analog and pin inputs
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    wire  [NSYNC-1:0] raw_in = {i_power_on_low, i_supply_below_threshold, i_detector_ready,
                                i_low_power_supply_drop_reset, i_external_reset_pin_n};
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    wire por_low   = sync2[4];
    wire below     = sync2[3];
    wire det_ready = sync2[2];
    wire lp_bor    = sync2[1];
    wire pin_n     = sync2[0];

    logic       sw_enable;
    logic       fast_start;
    logic [31:0] dip_cnt;
    logic        main_bor;
    logic [31:0] put_cnt;
    seq_e        state;
    seq_e        next_state;
    logic        was_sleep;

    // detector activity per mode
    wire mode_on    = (i_supply_drop_mode == MODE_ALWAYS_ON);
    wire mode_nslp  = (i_supply_drop_mode == MODE_OFF_IN_SLEEP);
    wire mode_sw    = (i_supply_drop_mode == MODE_SOFTWARE);
    wire det_enable = mode_on | (mode_nslp & ~i_sleep) | (mode_sw & sw_enable);
    wire det_active = det_enable & det_ready;
    wire start_wait = mode_on | mode_nslp;
    wire start_ok   = ~start_wait | (det_ready & ~below);
    wire bor_req    = main_bor | lp_bor;
    wire power_rst  = por_low | bor_req | i_program_mode_exit;
    wire stack_rst  = i_stack_fault_reset_enable & (i_stack_overflow | i_stack_underflow);
    wire pin_rst    = i_external_reset_pin_enable & ~pin_n;
    wire other_rst  = pin_rst | i_watchdog_timer_reset | i_reset_instruction | stack_rst;

    // dip filter: reset only after DIP_COUNT+1 consecutive low samples
    always_ff @(posedge i_mclk) begin
        if (i_rst || !det_active || !below) begin
            dip_cnt  <= 32'h0;
            main_bor <= 1'b0;
        end else if (dip_cnt >= DIP_COUNT) begin
            main_bor <= 1'b1;
        end else begin
            dip_cnt <= dip_cnt + 32'h1;
        end
    end

    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_POWER:      if (!power_rst) next_state = i_power_up_timer_enable_n ? ST_WAIT_READY : ST_TIMER;
            ST_TIMER:      if (put_cnt >= PUT_COUNT - 1) next_state = ST_WAIT_READY;
            ST_WAIT_READY: if (start_ok) next_state = ST_HOLD;
            ST_HOLD:       if (!other_rst) next_state = ST_RUN;
            ST_RUN:        if (i_sleep) next_state = ST_WAKE;
            ST_WAKE:       if (i_wake_request && (!mode_nslp || det_ready)) next_state = ST_RUN;
            default:       next_state = ST_POWER;
        endcase
        if (power_rst) next_state = ST_POWER;
        else if (other_rst && state != ST_POWER && state != ST_TIMER) next_state = ST_HOLD;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state   <= ST_POWER;
            put_cnt <= 32'h0;
        end else begin
            state   <= next_state;
            put_cnt <= (state == ST_TIMER && !power_rst) ? put_cnt + 32'h1 : 32'h0;
        end
    end

    wire sleep_run = (state == ST_RUN) | (state == ST_WAKE);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_internal_reset    <= 1'b1;
            o_run_enable        <= 1'b0;
            o_detector_enable   <= 1'b0;
            o_bandgap_force_on  <= 1'b0;
            o_supply_drop_reset <= 1'b0;
        end else begin
            o_internal_reset    <= ~sleep_run;
            o_run_enable        <= (state == ST_RUN);
            o_detector_enable   <= det_enable;
            o_bandgap_force_on  <= fast_start & (mode_nslp | mode_sw);
            o_supply_drop_reset <= bor_req;
        end
    end

    // AXI4-Lite slave
    logic        aw_hold;
    logic        w_hold;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire do_write = aw_hold & w_hold & ~s_axi_bvalid;
    wire wr_ctrl  = do_write & (aw_addr == BROWNOUT_CONTROL_ADDR) & w_strb[0];
    wire wr_hit   = (aw_addr == BROWNOUT_CONTROL_ADDR) | (aw_addr == SEQ_STATUS_ADDR);
    wire rd_ctrl  = (s_axi_araddr == BROWNOUT_CONTROL_ADDR);
    wire rd_stat  = (s_axi_araddr == SEQ_STATUS_ADDR);
    wire [31:0] ctrl_word = {24'h0, sw_enable, fast_start, 5'h00, det_active};
    wire [31:0] stat_word = {29'h0, state};
    wire [31:0] rd_word   = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic aw_hold_q;
    logic w_hold_q;
    assign s_axi_awready = ~aw_hold_q;
    assign s_axi_wready  = ~w_hold_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            aw_hold_q <= (aw_hold | (s_axi_awvalid & ~aw_hold_q)) & ~do_write;
            w_hold_q  <= (w_hold | (s_axi_wvalid & ~w_hold_q)) & ~do_write;
        end
    end

    // control bits: reset only by power-on / brown-out / program-mode exit
    always_ff @(posedge i_mclk) begin
        if (i_rst || power_rst) begin
            sw_enable  <= SW_ENABLE_RESET;
            fast_start <= FAST_START_RESET;
        end else if (wr_ctrl) begin
            sw_enable  <= w_data[SW_ENABLE_BIT];
            fast_start <= w_data[FAST_START_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_ctrl || rd_stat) ? AXI_OKAY : AXI_DECERR;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // assertions
    property p_power_hold;
        @(posedge i_mclk) disable iff (i_rst) por_low |-> ##2 o_internal_reset;
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("reset released under low supply");
    property p_timer_hold;
        @(posedge i_mclk) disable iff (i_rst) state == ST_TIMER |=> o_internal_reset;
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("reset released while timer counts");
    property p_timer_bypass;
        @(posedge i_mclk) disable iff (i_rst)
            (state == ST_POWER && !power_rst && i_power_up_timer_enable_n) |=> state != ST_TIMER;
    endproperty
    a_timer_bypass: assert property (p_timer_bypass) else $error("timer ran while disabled");
    property p_off_mode;
        @(posedge i_mclk) disable iff (i_rst) (i_supply_drop_mode == MODE_ALWAYS_OFF) |=> !main_bor;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("brown-out in off mode");
    property p_sw_mode;
        @(posedge i_mclk) disable iff (i_rst) (mode_sw && !sw_enable) |=> !o_detector_enable;
    endproperty
    a_sw_mode: assert property (p_sw_mode) else $error("detector on with software enable low");
    property p_fast;
        @(posedge i_mclk) disable iff (i_rst) (mode_on || i_supply_drop_mode == MODE_ALWAYS_OFF) |=> !o_bandgap_force_on;
    endproperty
    a_fast: assert property (p_fast) else $error("band gap forced in wrong mode");
    property p_lp;
        @(posedge i_mclk) disable iff (i_rst) lp_bor |=> o_supply_drop_reset ##1 o_internal_reset;
    endproperty
    a_lp: assert property (p_lp) else $error("low-power brown-out not ORed");
    property p_pin;
        @(posedge i_mclk) disable iff (i_rst) (pin_rst && state == ST_HOLD) |=> !o_run_enable;
    endproperty
    a_pin: assert property (p_pin) else $error("ran with pin held");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import reset_brownout_pkg::*;
    localparam int PUT = 20;
    localparam int DIP = 4;
    logic        i_mclk = 1'b0, i_rst = 1'b1, i_power_on_low = 1'b1, i_supply_below_threshold = 1'b0;
    logic        i_detector_ready = 1'b1, i_low_power_supply_drop_reset = 1'b0, i_external_reset_pin_enable = 1'b1;
    logic        i_stack_fault_reset_enable = 1'b1, i_program_mode_exit = 1'b0, i_power_up_timer_enable_n = 1'b0;
    logic [1:0]  i_supply_drop_mode = MODE_ALWAYS_ON;
    logic        i_sleep = 1'b0, i_wake_request = 1'b0;
    logic [4:0]  src = 5'h00;
    wire logic   i_watchdog_timer_reset = src[0];
    wire logic   i_reset_instruction = src[1];
    wire logic   i_stack_overflow = src[2];
    wire logic   i_stack_underflow = src[3];
    wire logic   i_external_reset_pin_n = ~src[4];
    logic        o_internal_reset, o_run_enable, o_detector_enable, o_bandgap_force_on, o_supply_drop_reset;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0]  outs;
    int          err_total = 0;
    int          checks = 0;

    assign outs = {o_internal_reset, o_run_enable, o_detector_enable, o_bandgap_force_on, o_supply_drop_reset};

    reset_brownout_sequencer #(.PUT_COUNT(PUT), .DIP_COUNT(DIP)) dut_u (
        .i_mclk, .i_rst, .i_power_on_low, .i_supply_below_threshold, .i_detector_ready,
        .i_low_power_supply_drop_reset, .i_external_reset_pin_n, .i_external_reset_pin_enable,
        .i_watchdog_timer_reset, .i_reset_instruction, .i_stack_overflow, .i_stack_underflow,
        .i_stack_fault_reset_enable, .i_program_mode_exit, .i_power_up_timer_enable_n, .i_supply_drop_mode,
        .i_sleep, .i_wake_request, .o_internal_reset, .o_run_enable, .o_detector_enable, .o_bandgap_force_on,
        .o_supply_drop_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    always #20 i_mclk = ~i_mclk;

    task automatic summarize;
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // waits for one output to reach a level, bounded
    task automatic wait_out(input int k, input logic v, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge i_mclk);
            if (outs[k] === v) break;
        end
        chk(32'(outs[k]), 32'(v));
        if (n == lim) summarize();
    endtask

    task automatic hold_out(input int k, input logic v, input int cyc);
        repeat (cyc) begin
            @(posedge i_mclk);
            chk(32'(outs[k]), 32'(v));
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge i_mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        chk(32'(s_axi_bresp), 32'(AXI_OKAY));
        if (n == 100) summarize();
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] resp);
        int n;
        @(posedge i_mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(resp));
        if (n == 100) summarize();
    endtask

    initial begin
        int n;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        hold_out(4, 1'b1, 6);
        i_power_on_low <= 1'b0;
        wait_out(4, 1'b0, PUT + 20, n);
        chk(32'(n >= PUT), 32'h1);
        wait_out(3, 1'b1, 10, n);
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'h81, AXI_OKAY);
        axi_wr(BROWNOUT_CONTROL_ADDR, 32'hFF);
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'hC1, AXI_OKAY);
        rd_chk(4'h8, 32'h0, AXI_DECERR);
        for (int k = 0; k < 5; k++) begin
            src <= 5'(1 << k);
            wait_out(4, 1'b1, 8, n);
            src <= 5'h00;
            wait_out(4, 1'b0, PUT - 2, n);
        end
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'hC1, AXI_OKAY);
        i_supply_below_threshold <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_supply_below_threshold <= 1'b0;
        hold_out(0, 1'b0, DIP + 6);
        i_supply_below_threshold <= 1'b1;
        wait_out(0, 1'b1, DIP + 8, n);
        chk(32'(n >= DIP), 32'h1);
        i_supply_below_threshold <= 1'b0;
        wait_out(4, 1'b0, PUT + 20, n);
        chk(32'(n >= PUT), 32'h1);
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'h81, AXI_OKAY);
        i_low_power_supply_drop_reset <= 1'b1;
        wait_out(0, 1'b1, DIP + 8, n);
        i_low_power_supply_drop_reset <= 1'b0;
        wait_out(4, 1'b0, PUT + 20, n);
        i_supply_drop_mode <= MODE_ALWAYS_OFF;
        wait_out(2, 1'b0, 8, n);
        i_supply_below_threshold <= 1'b1;
        hold_out(0, 1'b0, DIP + 6);
        i_supply_below_threshold <= 1'b0;
        i_supply_drop_mode <= MODE_SOFTWARE;
        wait_out(2, 1'b1, 8, n);
        axi_wr(BROWNOUT_CONTROL_ADDR, 32'h40);
        wait_out(2, 1'b0, 8, n);
        wait_out(1, 1'b1, 8, n);
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'h40, AXI_OKAY);
        i_supply_below_threshold <= 1'b1;
        hold_out(0, 1'b0, DIP + 6);
        i_supply_below_threshold <= 1'b0;
        axi_wr(BROWNOUT_CONTROL_ADDR, 32'hC0);
        wait_out(2, 1'b1, 8, n);
        i_sleep <= 1'b1;
        hold_out(2, 1'b1, 6);
        i_supply_drop_mode <= MODE_OFF_IN_SLEEP;
        wait_out(2, 1'b0, 8, n);
        i_sleep <= 1'b0;
        i_wake_request <= 1'b1;
        wait_out(3, 1'b1, 8, n);
        i_wake_request <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            i_supply_drop_mode <= 2'(m);
            wait_out(1, 1'(m == 1 || m == 2), 8, n);
        end
        i_power_up_timer_enable_n <= 1'b1;
        i_program_mode_exit <= 1'b1;
        wait_out(4, 1'b1, 8, n);
        i_program_mode_exit <= 1'b0;
        wait_out(4, 1'b0, PUT - 4, n);
        rd_chk(BROWNOUT_CONTROL_ADDR, 32'h81, AXI_OKAY);
        summarize();
    end
endmodule
`default_nettype wire
